// ---- logic/bsio_ports.sv ----
// Purpose: two 8-bit general-purpose ports shared with the external memory bus
// Assumes: ahb-lite slave, one clock, pins synchronous to sys_clk
// Notes: pin drive and pin capture are registered, one cycle each way
`timescale 1ns/1ps
`default_nettype none

`include "bsio_defs.svh"

module bsio_ports (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic busModeStrap,
  input wire bsio_pkg::bsio_ebc_t ebcReq,
  output logic busModeMux,
  output logic [15:0] busDataIn,
  input wire logic [7:0] port0In,
  output logic [7:0] port0Out,
  output logic [7:0] port0Oe,
  input wire logic [7:0] port1In,
  output logic [7:0] port1Out,
  output logic [7:0] port1Oe
);

  // register state
  logic [7:0] p0Latch;
  logic [7:0] p0Dir;
  logic [7:0] p1Latch;
  logic [7:0] p1Dir;
  logic [7:0] p1Fn;
  bsio_pkg::bsio_ap_t addrPhase;

  logic [7:0] next_p0Latch;
  logic [7:0] next_p0Dir;
  logic [7:0] next_p1Latch;
  logic [7:0] next_p1Dir;
  logic [7:0] next_p1Fn;
  bsio_pkg::bsio_ap_t next_addrPhase;

  // bus answer and pin state
  logic [31:0] next_hrdata;
  logic next_busModeMux;
  logic [15:0] next_busDataIn;
  logic [7:0] next_port0Out;
  logic [7:0] next_port0Oe;
  logic [7:0] p1MuxOut;
  logic [7:0] p1MuxOe;

  // captured pin levels
  logic [7:0] p0Pin;
  logic [7:0] p1Pin;

  // byte address of a register index; the top index bits fall off the word
  function automatic logic [31:0] byteAddr(input logic [31:0] idx);
    return {idx[29:0], 2'b00};
  endfunction

  // address decode of one aligned word per register
  function automatic bsio_pkg::bsio_reg_t decode(input logic [31:0] addr);
    bsio_pkg::bsio_reg_t sel;
    sel = bsio_pkg::BSIO_REG_NONE;
    if (addr == byteAddr(`BSIO_IDX_P0DATA))
      sel = bsio_pkg::BSIO_REG_P0DATA;
    else if (addr == byteAddr(`BSIO_IDX_P1DATA))
      sel = bsio_pkg::BSIO_REG_P1DATA;
    else if (addr == byteAddr(`BSIO_IDX_P0DIR))
      sel = bsio_pkg::BSIO_REG_P0DIR;
    else if (addr == byteAddr(`BSIO_IDX_P1DIR))
      sel = bsio_pkg::BSIO_REG_P1DIR;
    else if (addr == byteAddr(`BSIO_IDX_P1FN))
      sel = bsio_pkg::BSIO_REG_P1FN;
    return sel;
  endfunction

  // pin for input bits, latch for output bits
  function automatic logic [7:0] mixRead(
    input logic [7:0] latch,
    input logic [7:0] outMask,
    input logic [7:0] pin
  );
    return (latch & outMask) | (pin & ~outMask);
  endfunction

  // byte seen by a read of one register
  function automatic logic [7:0] readByte(
    input bsio_pkg::bsio_reg_t sel,
    input logic [7:0] l0,
    input logic [7:0] d0,
    input logic [7:0] l1,
    input logic [7:0] d1,
    input logic [7:0] f1,
    input logic [7:0] pin0,
    input logic [7:0] pin1
  );
    logic [7:0] val;
    val = `BSIO_RST_BYTE;
    case (sel)
      bsio_pkg::BSIO_REG_P0DATA: val = mixRead(l0, d0, pin0);
      // only the plain output code counts as output for port 1
      bsio_pkg::BSIO_REG_P1DATA: val = mixRead(l1, d1 & ~f1, pin1);
      bsio_pkg::BSIO_REG_P0DIR: val = d0;
      bsio_pkg::BSIO_REG_P1DIR: val = d1;
      bsio_pkg::BSIO_REG_P1FN: val = f1;
      default: val = `BSIO_RST_BYTE;
    endcase
    return val;
  endfunction

  assign p0Pin = busDataIn[7:0];
  assign p1Pin = busDataIn[15:8];

  // address phase capture; hsize is only ever a whole word here
  always_comb
  begin
    next_addrPhase = addrPhase;
    if (hready)
    begin
      next_addrPhase.valid = hsel & htrans[`BSIO_HTRANS_ACTIVE_BIT];
      next_addrPhase.write = hwrite;
      next_addrPhase.sel = decode(haddr);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      addrPhase.valid <= 1'b0;
      addrPhase.write <= 1'b0;
      addrPhase.sel <= bsio_pkg::BSIO_REG_NONE;
    end
    else
    begin
      addrPhase <= next_addrPhase;
    end
  end

  // register writes in the data phase; unmapped writes are dropped
  always_comb
  begin
    next_p0Latch = p0Latch;
    next_p0Dir = p0Dir;
    next_p1Latch = p1Latch;
    next_p1Dir = p1Dir;
    next_p1Fn = p1Fn;
    if (addrPhase.valid && addrPhase.write)
    begin
      case (addrPhase.sel)
        bsio_pkg::BSIO_REG_P0DATA: next_p0Latch = hwdata[`BSIO_BYTE_MSB:0];
        bsio_pkg::BSIO_REG_P1DATA: next_p1Latch = hwdata[`BSIO_BYTE_MSB:0];
        bsio_pkg::BSIO_REG_P0DIR: next_p0Dir = hwdata[`BSIO_BYTE_MSB:0];
        bsio_pkg::BSIO_REG_P1DIR: next_p1Dir = hwdata[`BSIO_BYTE_MSB:0];
        bsio_pkg::BSIO_REG_P1FN: next_p1Fn = hwdata[`BSIO_BYTE_MSB:0];
        default: next_p0Latch = p0Latch;
      endcase
    end
    // hardware clear beats a software write landing in the same cycle
    if (ebcReq.active)
      next_p0Dir = `BSIO_RST_BYTE;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      p0Latch <= `BSIO_RST_BYTE;
      p0Dir <= `BSIO_RST_BYTE;
      p1Latch <= `BSIO_RST_BYTE;
      p1Dir <= `BSIO_RST_BYTE;
      p1Fn <= `BSIO_RST_BYTE;
    end
    else
    begin
      p0Latch <= next_p0Latch;
      p0Dir <= next_p0Dir;
      p1Latch <= next_p1Latch;
      p1Dir <= next_p1Dir;
      p1Fn <= next_p1Fn;
    end
  end

  // read data built from post-write values, so a read right after a write
  // sees it without a wait state
  always_comb
  begin
    next_hrdata = `BSIO_RST_WORD;
    if (hready && hsel && htrans[`BSIO_HTRANS_ACTIVE_BIT] && !hwrite)
    begin
      next_hrdata = {`BSIO_PAD_ZERO,
        readByte(decode(haddr), next_p0Latch, next_p0Dir, next_p1Latch,
          next_p1Dir, next_p1Fn, p0Pin, p1Pin)};
    end
  end

  // zero-wait slave, always okay
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      hrdata <= `BSIO_RST_WORD;
      hreadyout <= `BSIO_READY;
      hresp <= `BSIO_HRESP_OKAY;
    end
    else
    begin
      hrdata <= next_hrdata;
      hreadyout <= `BSIO_READY;
      hresp <= `BSIO_HRESP_OKAY;
    end
  end

  // strap is held while reset is low and frozen at release
  always_comb
  begin
    next_busModeMux = busModeMux;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      busModeMux <= busModeStrap;
    else
      busModeMux <= next_busModeMux;
  end

  // pin capture for reads and for the bus controller's incoming data
  always_comb
  begin
    next_busDataIn = {port1In, port0In};
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      busDataIn <= {`BSIO_RST_BYTE, `BSIO_RST_BYTE};
    else
      busDataIn <= next_busDataIn;
  end

  // port 1 roles follow software settings only, never the bus activity
  bsio_port1_mux u_p1mux (
    .fnBits(next_p1Fn),
    .dirBits(next_p1Dir),
    .latch(next_p1Latch),
    .ebcReq(ebcReq),
    .pinOut(p1MuxOut),
    .pinOe(p1MuxOe)
  );

  // port 0 drive; the controller formats data or address-data per busModeMux
  always_comb
  begin
    next_port0Out = next_p0Latch;
    next_port0Oe = next_p0Dir;
    if (ebcReq.active)
    begin
      next_port0Out = ebcReq.lowOut;
      next_port0Oe = {8{ebcReq.lowOe}};
    end
  end

  // pins registered so every output leaves a flop
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      port0Out <= `BSIO_RST_BYTE;
      port0Oe <= `BSIO_RST_BYTE;
      port1Out <= `BSIO_RST_BYTE;
      port1Oe <= `BSIO_RST_BYTE;
    end
    else
    begin
      port0Out <= next_port0Out;
      port0Oe <= next_port0Oe;
      port1Out <= p1MuxOut;
      port1Oe <= p1MuxOe;
    end
  end

  // hsize is not checked: only single word transfers reach this slave
  logic unusedSize;
  assign unusedSize = ^hsize;

endmodule

`default_nettype wire

// ---- logic/bsio_defs.svh ----
// Purpose: offsets, reset values and bus codes for the shared i/o ports
// Assumes: printed offsets are register indices; byte address is four times that
// Notes: definitions only
`ifndef BSIO_DEFS_SVH
`define BSIO_DEFS_SVH

// register indices as printed
`define BSIO_IDX_P0DATA 32'hfffff000
`define BSIO_IDX_P1DATA 32'hfffff001
`define BSIO_IDX_P0DIR 32'hfffff002
`define BSIO_IDX_P1DIR 32'hfffff004
`define BSIO_IDX_P1FN 32'hfffff005

// reset values
`define BSIO_RST_BYTE 8'h00
`define BSIO_RST_WORD 32'h00000000
`define BSIO_RST_STRAP 1'b0

// ahb-lite codes
`define BSIO_HTRANS_ACTIVE_BIT 1
`define BSIO_HRESP_OKAY 1'b0
`define BSIO_READY 1'b1

// field layout
`define BSIO_BYTE_MSB 7
`define BSIO_PAD_ZERO 24'h000000

`endif

// ---- logic/bsio_pkg.sv ----
// Purpose: shared types of the shared i/o ports
// Assumes: used with package-qualified names only
// Notes: no constants here; numbers live in bsio_defs.svh
package bsio_pkg;

  // request from the external bus controller
  typedef struct packed {
    logic active;
    logic [7:0] lowOut;
    logic lowOe;
    logic [7:0] highOut;
    logic highOe;
    logic [7:0] midAddr;
  } bsio_ebc_t;

  // decoded register select
  typedef enum logic [2:0] {
    BSIO_REG_NONE,
    BSIO_REG_P0DATA,
    BSIO_REG_P1DATA,
    BSIO_REG_P0DIR,
    BSIO_REG_P1DIR,
    BSIO_REG_P1FN
  } bsio_reg_t;

  // port 1 pin role from the function/direction pair
  typedef enum logic [1:0] {
    BSIO_FN_IN,
    BSIO_FN_OUT,
    BSIO_FN_HIDATA,
    BSIO_FN_MIDADDR
  } bsio_p1fn_t;

  // captured ahb address phase
  typedef struct packed {
    logic valid;
    logic write;
    bsio_reg_t sel;
  } bsio_ap_t;

endpackage

// ---- logic/bsio_port1_mux.sv ----
// Purpose: per-pin role selection for port 1
// Assumes: bus values come from the external bus controller
// Notes: purely combinational; the caller registers the result
`timescale 1ns/1ps
`default_nettype none

`include "bsio_defs.svh"

module bsio_port1_mux (
  input wire logic [7:0] fnBits,
  input wire logic [7:0] dirBits,
  input wire logic [7:0] latch,
  input wire bsio_pkg::bsio_ebc_t ebcReq,
  output logic [7:0] pinOut,
  output logic [7:0] pinOe
);

  // pair decode of function and direction bit
  function automatic bsio_pkg::bsio_p1fn_t roleOf(input logic fn, input logic dir);
    bsio_pkg::bsio_p1fn_t role;
    case ({fn, dir})
      2'b00: role = bsio_pkg::BSIO_FN_IN;
      2'b01: role = bsio_pkg::BSIO_FN_OUT;
      2'b10: role = bsio_pkg::BSIO_FN_HIDATA;
      default: role = bsio_pkg::BSIO_FN_MIDADDR;
    endcase
    return role;
  endfunction

  // each pin picks latch, upper data lines or middle address lines
  always_comb
  begin
    pinOut = `BSIO_RST_BYTE;
    pinOe = `BSIO_RST_BYTE;
    for (int i = 0; i < 8; i++)
    begin
      case (roleOf(fnBits[i], dirBits[i]))
        bsio_pkg::BSIO_FN_OUT:
        begin
          pinOut[i] = latch[i];
          pinOe[i] = 1'b1;
        end
        bsio_pkg::BSIO_FN_HIDATA:
        begin
          // data direction belongs to the bus controller, and only while it runs
          pinOut[i] = ebcReq.highOut[i];
          pinOe[i] = ebcReq.active & ebcReq.highOe;
        end
        bsio_pkg::BSIO_FN_MIDADDR:
        begin
          pinOut[i] = ebcReq.midAddr[i];
          pinOe[i] = 1'b1;
        end
        default:
        begin
          pinOut[i] = latch[i];
          pinOe[i] = 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ---- test/bsio_ports_assertions.sv ----
// Purpose: port checks for the shared i/o ports
// Assumes: zero-wait ahb, one clock
// Notes: register shadow rebuilt from bus writes
`timescale 1ns/1ps
`default_nettype none
`include "bsio_defs.svh"
module bsio_ports_assertions (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic busModeStrap,
  input wire bsio_pkg::bsio_ebc_t ebcReq,
  input wire logic busModeMux,
  input wire logic [15:0] busDataIn,
  input wire logic [7:0] port0In,
  input wire logic [7:0] port0Out,
  input wire logic [7:0] port0Oe,
  input wire logic [7:0] port1In,
  input wire logic [7:0] port1Out,
  input wire logic [7:0] port1Oe
);
  localparam logic [31:0] KD0 = `BSIO_IDX_P0DATA << 2;
  localparam logic [31:0] KD1 = `BSIO_IDX_P1DATA << 2;
  localparam logic [31:0] KR0 = `BSIO_IDX_P0DIR << 2;
  localparam logic [31:0] KR1 = `BSIO_IDX_P1DIR << 2;
  localparam logic [31:0] KF1 = `BSIO_IDX_P1FN << 2;
  logic apV;
  logic apW;
  logic [31:0] apA;
  logic [7:0] lat0, dir0, lat1, dir1, fn1, m1, rdExp;
  logic [15:0] pinQ;
  // shadow loads at the end of a write data phase
  always_ff @(posedge sys_clk)
  begin
    pinQ <= busDataIn;
    if (!reset_n)
    begin
      apV <= 1'b0;
      {lat0, dir0, lat1, dir1, fn1} <= 40'h0;
    end
    else
    begin
      apV <= hsel && htrans[1] && hready;
      apW <= hwrite;
      apA <= haddr;
      if (apV && apW)
      begin
        case (apA)
          KD0: lat0 <= hwdata[7:0];
          KD1: lat1 <= hwdata[7:0];
          KR0: dir0 <= hwdata[7:0];
          KR1: dir1 <= hwdata[7:0];
          KF1: fn1 <= hwdata[7:0];
          default: ;
        endcase
      end
      // clear wins over a same-cycle write
      if (ebcReq.active)
        dir0 <= 8'h00;
    end
  end
  // expected read data; pins as captured before the address phase
  always_comb
  begin
    m1 = ~fn1 & dir1;
    case (apA)
      KD0: rdExp = (lat0 & dir0) | (pinQ[7:0] & ~dir0);
      KD1: rdExp = (lat1 & m1) | (pinQ[15:8] & ~m1);
      KR0: rdExp = dir0;
      KR1: rdExp = dir1;
      KF1: rdExp = fn1;
      default: rdExp = 8'h00;
    endcase
  end
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  sequence addrRd;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  rst_clear_a: assert property ($rose(reset_n) |->
    {port0Out, port0Oe, port1Out, port1Oe} == 32'h0) else $error("pins not cleared");
  strap_take_a: assert property ($rose(reset_n) |->
    busModeMux == $past(busModeStrap)) else $error("strap not captured");
  strap_hold_a: assert property ($past(reset_n) |-> $stable(busModeMux))
    else $error("bus mode moved");
  p0_oe_a: assert property ($past(reset_n) |-> port0Oe ==
    ($past(ebcReq.active) ? {8{$past(ebcReq.lowOe)}} : dir0)) else $error("port0 oe");
  p0_out_a: assert property ($past(reset_n) |-> (port0Out & port0Oe) ==
    (($past(ebcReq.active) ? $past(ebcReq.lowOut) : lat0) & port0Oe)) else $error("port0 out");
  p1_oe_a: assert property ($past(reset_n) |-> port1Oe ==
    (dir1 | (fn1 & {8{$past(ebcReq.active && ebcReq.highOe)}}))) else $error("port1 oe");
  p1_out_a: assert property ($past(reset_n) |-> (port1Out & port1Oe) ==
    (((m1 & lat1) | (fn1 & dir1 & $past(ebcReq.midAddr))
    | (fn1 & ~dir1 & $past(ebcReq.highOut))) & port1Oe)) else $error("port1 out");
  rd_data_a: assert property (addrRd |=> hrdata == {24'h0, rdExp})
    else $error("read data wrong");
  pin_take_a: assert property ($past(reset_n) |->
    busDataIn == $past({port1In, port0In})) else $error("pin capture wrong");
endmodule
bind bsio_ports bsio_ports_assertions chk_u (
  .sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout,
  .hresp, .hrdata, .busModeStrap, .ebcReq, .busModeMux, .busDataIn, .port0In,
  .port0Out, .port0Oe, .port1In, .port1Out, .port1Oe
);
`default_nettype wire

// ---- test/bsio_ext_mem.sv ----
// Purpose: far side of the shared pins
// Assumes: port drive wins where its enable is high; the device sets the other lines
// Notes: lines nobody drives churn every cycle
`timescale 1ns/1ps
`default_nettype none
module bsio_ext_mem (
  input wire logic sys_clk,
  input wire logic extEn,
  input wire logic [15:0] extVal,
  input wire logic [7:0] port0Out,
  input wire logic [7:0] port0Oe,
  input wire logic [7:0] port1Out,
  input wire logic [7:0] port1Oe,
  output logic [7:0] port0In,
  output logic [7:0] port1In
);
  logic [15:0] churn = 16'h0000;
  logic [15:0] far;
  // released lines never hold the last value
  always @(posedge sys_clk)
  begin
    churn <= churn + 16'h3c5b;
  end
  // wire level from both parties
  always_comb
  begin
    far = extEn ? extVal : churn;
    port0In = (port0Oe & port0Out) | (~port0Oe & far[7:0]);
    port1In = (port1Oe & port1Out) | (~port1Oe & far[15:8]);
  end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Purpose: register and pin tests of the shared i/o ports
// Assumes: zero-wait ahb slave
// Notes: pins come from the far-side model
`timescale 1ns/1ps
`default_nettype none
`include "bsio_defs.svh"
module tb_top;
  localparam logic [31:0] KD0 = `BSIO_IDX_P0DATA << 2;
  localparam logic [31:0] KD1 = `BSIO_IDX_P1DATA << 2;
  localparam logic [31:0] KR0 = `BSIO_IDX_P0DIR << 2;
  localparam logic [31:0] KR1 = `BSIO_IDX_P1DIR << 2;
  localparam logic [31:0] KF1 = `BSIO_IDX_P1FN << 2;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic busModeStrap = 1'b1;
  bsio_pkg::bsio_ebc_t ebcReq = '0;
  logic extEn = 1'b1;
  logic [15:0] extVal = 16'ha55a;
  logic hreadyout, hresp, busModeMux;
  logic [31:0] hrdata;
  logic [15:0] busDataIn;
  logic [7:0] port0In, port0Out, port0Oe, port1In, port1Out, port1Oe;
  int fails = 0;
  int cmp_count = 0;
  always #20 sys_clk = ~sys_clk;
  bsio_ports dut_u (.sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .busModeStrap, .ebcReq,
    .busModeMux, .busDataIn, .port0In, .port0Out, .port0Oe, .port1In, .port1Out, .port1Oe);
  bsio_ext_mem far_u (.sys_clk, .extEn, .extVal, .port0Out, .port0Oe, .port1Out,
    .port1Oe, .port0In, .port1In);
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one single transfer; waits on hready in both phases
  task xfer(input logic [31:0] a, input logic wr, input logic [7:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task rd(input string nm, input logic [31:0] a, input logic [7:0] exp);
    logic [31:0] q;
    xfer(a, 1'b0, 8'h00, q);
    check(nm, q, {24'h0, exp});
  endtask
  // outputs settle one edge after their cause
  task look;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    busModeStrap <= 1'b0;
    rd("dir0", KR0, 8'h00);
    rd("dir1", KR1, 8'h00);
    rd("fn1", KF1, 8'h00);
    rd("p0 pins", KD0, extVal[7:0]);
    rd("p1 pins", KD1, extVal[15:8]);
    rd("unmapped", KD0 + 32'hc, 8'h00);
    #1;
    check("mux", busModeMux, 32'h1);
    check("p1oe", port1Oe, 32'h0);
    $display("test reset done");
    wr(KR0, 8'hff);
    look;
    check("p0 latch", port0Out, 32'h0);
    wr(KR0, 8'ha5);
    wr(KD0, 8'h3c);
    wr(KD0 + 32'hc, 8'hff);
    look;
    check("p0oe", port0Oe, 32'ha5);
    check("p0out", port0Out & 8'ha5, 32'h24);
    rd("p0 mixed", KD0, 8'h24 | (extVal[7:0] & 8'h5a));
    $display("test port0 done");
    wr(KF1, 8'hf0);
    wr(KR1, 8'hcc);
    wr(KD1, 8'hff);
    @(posedge sys_clk);
    ebcReq <= '{1'b1, 8'h96, 1'b1, 8'h3c, 1'b1, 8'h5a};
    look;
    check("p0 bus oe", port0Oe, 32'hff);
    check("p0 bus out", port0Out, 32'h96);
    check("p1 bus oe", port1Oe, 32'hfc);
    check("p1 bus out", port1Out & 8'hfc, 32'h7c);
    @(posedge sys_clk);
    ebcReq.active <= 1'b0;
    look;
    check("p0 idle oe", port0Oe, 32'h0);
    check("p1 idle oe", port1Oe, 32'hcc);
    rd("dir0 cleared", KR0, 8'h00);
    rd("p1 mixed", KD1, 8'h0c | ((8'h4c | (8'h33 & extVal[15:8])) & 8'hf3));
    $display("test bus share done");
    reset_n <= 1'b0;
    look;
    @(posedge sys_clk);
    reset_n <= 1'b1;
    busModeStrap <= 1'b1;
    look;
    check("mux sep", busModeMux, 32'h0);
    check("p1oe rst", port1Oe, 32'h0);
    rd("fn1 rst", KF1, 8'h00);
    $display("test second reset done");
    complete_run;
  end
  // hang guard, well beyond the fewer than one hundred cycles used
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    fails++;
    complete_run;
  end
endmodule
`default_nettype wire
